// [bench/tb_top.sv]
/*
 * self-checking bench for osc_select_pll_translation: reset values, field
 * write and read back, crystal table, read-only and unmapped accesses,
 * byte lanes and a reset in mid-run.
 * polls waitrequest on each access and gives up after 100 wait cycles.
 */
`timescale 1ns/1ps

module tb_top;
  import osc_pll_pkg::*;

  // ------------------------------------------------------------------
  // signals and counters
  // ------------------------------------------------------------------
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [ADDR_W-1:0] address = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [DATA_W-1:0] writedata = '0;
  logic [BE_W-1:0] byteenable = '0;
  logic [DATA_W-1:0] readdata;
  logic waitrequest;
  logic [1:0] response;
  osc_src_e clock_source_select;
  logic internal_osc_off;
  logic main_osc_off;
  pll_cfg_s pll_translation;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  logic [31:0] cfg_m; // expected config word
  logic [31:0] wd;
  logic [31:0] rd;
  logic [1:0] rs;
  localparam logic [31:0] CFG_MASK = 32'h0000_03f3;
  localparam int LIMIT = 20000;

  osc_select_pll_translation uut (
    .clk(clk),
    .srst(srst),
    .address(address),
    .read(read),
    .write(write),
    .writedata(writedata),
    .byteenable(byteenable),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .response(response),
    .clock_source_select(clock_source_select),
    .internal_osc_off(internal_osc_off),
    .main_osc_off(main_osc_off),
    .pll_translation(pll_translation)
  );

  always #5 clk = ~clk;

  // cycle ceiling, so a hung handshake still ends in the report
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // ------------------------------------------------------------------
  // expectations
  // ------------------------------------------------------------------
  // mult and ref_div per crystal code; codes below 4 have no pll setting
  function automatic logic [13:0] exp_pll(input logic [3:0] c);
    case (c)
      4'h4: return {9'h1bf, 5'h3};
      4'h5: return {9'h0d9, 5'h1};
      4'h6: return {9'h064, 5'h0};
      4'h7: return {9'h125, 5'h2};
      4'h8: return {9'h197, 5'h4};
      4'h9: return {9'h050, 5'h0};
      4'ha: return {9'h139, 5'h3};
      4'hb: return {9'h0c8, 5'h2};
      4'hc: return {9'h0c3, 5'h2};
      4'hd: return {9'h0d9, 5'h3};
      4'he: return {9'h032, 5'h0};
      4'hf: return {9'h0f4, 5'h4};
      default: return 14'h0;
    endcase
  endfunction

  // lane merge; unstored bits always read zero
  function automatic logic [31:0] merge(input logic [31:0] old, d, input logic [3:0] be);
    logic [31:0] m;
    for (int i = 0; i < 4; i++) begin
      m[8*i +: 8] = be[i] ? d[8*i +: 8] : old[8*i +: 8];
    end
    return m & CFG_MASK;
  endfunction

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one avalon access; an idle edge follows so no signal is set twice at once
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    address <= a;
    writedata <= d;
    byteenable <= be;
    read <= ~wr;
    write <= wr;
    @(posedge clk);
    while (waitrequest !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (n == 100) n_mismatch++;
    rd = readdata;
    rs = response;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic cfg_wr(input logic [31:0] d, input logic [3:0] be);
    bus(1'b1, RUN_CLOCK_CONFIG_OFS, d, be);
    cfg_m = merge(cfg_m, d, be);
  endtask

  // both registers by bus, then the level outputs at a quiet point
  task automatic check_all();
    bus(1'b0, RUN_CLOCK_CONFIG_OFS, $urandom(), 4'h0);
    chk("config", cfg_m, rd);
    chk("config resp", 32'(RESP_OKAY), 32'(rs));
    bus(1'b0, PLL_TRANSLATION_OFS, $urandom(), 4'h0);
    chk("pll reg", {18'h0, exp_pll(cfg_m[9:6])}, rd);
    @(negedge clk);
    chk("src", 32'(cfg_m[5:4]), 32'(clock_source_select));
    chk("internal_ring_source off", 32'(cfg_m[1]), 32'(internal_osc_off));
    chk("mosc off", 32'(cfg_m[0]), 32'(main_osc_off));
    chk("pll port", 32'(exp_pll(cfg_m[9:6])), 32'(pll_translation));
    @(posedge clk);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    void'($urandom(32'heee0b042));
    cfg_m = 32'h0000_02d1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    check_all();
    // every crystal code and source, noise in the unstored bits
    for (int i = 0; i < 16; i++) begin
      wd = $urandom();
      wd[9:4] = {4'(i), 2'(i)};
      cfg_wr(wd, 4'hf);
      check_all();
    end
    // random data on random lanes
    for (int i = 0; i < 30; i++) begin
      cfg_wr($urandom(), 4'($urandom()));
      check_all();
    end
    // internal/4 feeding the pll, both oscillators on
    cfg_wr(32'h0000_03e0, 4'hf);
    check_all();
    // translation register ignores writes
    bus(1'b1, PLL_TRANSLATION_OFS, 32'hffff_ffff, 4'hf);
    chk("ro resp", 32'(RESP_OKAY), 32'(rs));
    check_all();
    // unmapped place: no effect, decode error, zero data
    bus(1'b1, 12'h068, 32'hffff_ffff, 4'hf);
    chk("unmapped wr resp", 32'(RESP_DECODEERROR), 32'(rs));
    bus(1'b0, 12'h000, 32'h0, 4'h0);
    chk("unmapped rd", 32'h0, rd);
    chk("unmapped rd resp", 32'(RESP_DECODEERROR), 32'(rs));
    check_all();
    // reset in mid-run from a far-off setting
    cfg_wr(32'h0000_0032, 4'hf);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    cfg_m = 32'h0000_02d1;
    @(posedge clk);
    check_all();
    tally_and_finish();
  end

endmodule

// [logic/crystal_freq_code_pll_xlat.sv]
/*
 * crystal code to pll setting translation: a fixed table and the
 * register that holds its answer for the pll inputs.
 * assumes the crystal code comes from a register on the same clock.
 */
`timescale 1ns/1ps

module crystal_freq_code_pll_xlat
  import osc_pll_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [CRYSTAL_FREQ_CODE_MSB-CRYSTAL_FREQ_CODE_LSB:0] crystal_freq_code_code,
  output osc_pll_pkg::pll_cfg_s table_now,
  output osc_pll_pkg::pll_cfg_s pll_cfg_q
);

  // ----------------------------------------------------------------------
  // lookup table, every entry aims at a 400 mhz vco
  // ----------------------------------------------------------------------
  // codes below 0x4 are not usable with the pll, they give all zero
  function automatic pll_cfg_s lookup(input logic [CRYSTAL_FREQ_CODE_MSB-CRYSTAL_FREQ_CODE_LSB:0] code);
    pll_cfg_s v;
    v = '0;
    unique case (code)
      4'h4: v = '{mult: 9'd447, ref_div: 5'd3};
      4'h5: v = '{mult: 9'd217, ref_div: 5'd1};
      4'h6: v = '{mult: 9'd100, ref_div: 5'd0};
      4'h7: v = '{mult: 9'd293, ref_div: 5'd2};
      4'h8: v = '{mult: 9'd407, ref_div: 5'd4};
      4'h9: v = '{mult: 9'd80, ref_div: 5'd0};
      4'ha: v = '{mult: 9'd313, ref_div: 5'd3};
      4'hb: v = '{mult: 9'd200, ref_div: 5'd2};
      4'hc: v = '{mult: 9'd195, ref_div: 5'd2};
      4'hd: v = '{mult: 9'd217, ref_div: 5'd3};
      4'he: v = '{mult: 9'd50, ref_div: 5'd0};
      4'hf: v = '{mult: 9'd244, ref_div: 5'd4};
      default: v = '0;
    endcase
    return v;
  endfunction

  // table answer for the code in force, the reset code while in reset
  always_comb begin
    table_now = lookup(srst ? CRYSTAL_FREQ_CODE_RST : crystal_freq_code_code);
  end

  // follows the code every cycle, so any change lands one edge later
  always_ff @(posedge clk) begin
    if (srst) begin
      pll_cfg_q <= lookup(CRYSTAL_FREQ_CODE_RST);
    end else begin
      pll_cfg_q <= lookup(crystal_freq_code_code);
    end
  end

endmodule

// [logic/osc_pll_pkg.sv]
/*
 * shared constants and types for the oscillator select and crystal to
 * pll translation block: register offsets, field positions, reset values,
 * bus answer codes and the carriers that group related fields.
 * assumes a 32-bit avalon-mm register bus with byte addressing.
 */
package osc_pll_pkg;

  // ----------------------------------------------------------------------
  // bus geometry and register offsets
  // ----------------------------------------------------------------------
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned BE_W = DATA_W / 8;
  localparam logic [ADDR_W-1:0] RUN_CLOCK_CONFIG_OFS = 12'h060;
  localparam logic [ADDR_W-1:0] PLL_TRANSLATION_OFS = 12'h064;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int unsigned MOSC_OFF_BIT = 0;
  localparam int unsigned INT_OSC_OFF_BIT = 1;
  localparam int unsigned RSV_LSB = 2;
  localparam int unsigned RSV_MSB = 3;
  localparam int unsigned SRC_LSB = 4;
  localparam int unsigned SRC_MSB = 5;
  localparam int unsigned CRYSTAL_FREQ_CODE_LSB = 6;
  localparam int unsigned CRYSTAL_FREQ_CODE_MSB = 9;
  localparam int unsigned PLL_R_LSB = 0;
  localparam int unsigned PLL_R_MSB = 4;
  localparam int unsigned PLL_F_LSB = 5;
  localparam int unsigned PLL_F_MSB = 13;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_MAIN = 2'b00,
    SRC_INTERNAL = 2'b01,
    SRC_INTERNAL_DIV4 = 2'b10,
    SRC_SLOW_30K = 2'b11
  } osc_src_e;

  typedef struct packed {
    logic [CRYSTAL_FREQ_CODE_MSB-CRYSTAL_FREQ_CODE_LSB:0] crystal_freq_code;
    osc_src_e src;
    logic int_osc_off;
    logic mosc_off;
  } run_cfg_s;

  typedef struct packed {
    logic [PLL_F_MSB-PLL_F_LSB:0] mult;
    logic [PLL_R_MSB-PLL_R_LSB:0] ref_div;
  } pll_cfg_s;

  // ----------------------------------------------------------------------
  // reset values and bus answers
  // ----------------------------------------------------------------------
  localparam logic [CRYSTAL_FREQ_CODE_MSB-CRYSTAL_FREQ_CODE_LSB:0] CRYSTAL_FREQ_CODE_RST = 4'hb;
  localparam osc_src_e SRC_RST = SRC_INTERNAL;
  localparam logic INT_OSC_OFF_RST = 1'b0;
  localparam logic MOSC_OFF_RST = 1'b1;
  localparam run_cfg_s RUN_CFG_RST = '{crystal_freq_code: CRYSTAL_FREQ_CODE_RST, src: SRC_RST,
                                       int_osc_off: INT_OSC_OFF_RST, mosc_off: MOSC_OFF_RST};
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECODEERROR = 2'b11;

endpackage

// [logic/osc_select_pll_translation.sv]
/*
 * run-mode clock configuration, low fields: oscillator source select,
 * internal and main oscillator disables, crystal code, and the read-only
 * crystal to pll translation register, all behind an avalon-mm slave.
 * assumes a single clock, synchronous reset, and a master that holds its
 * request until it sees waitrequest low.
 */
//
// Summary of operation
// - two-bit source select, reset 0x1, picks main, internal, internal/4 or 30 khz.
// - internal oscillator off bit, reset 0, stops internal oscillator when set.
// - main oscillator off bit 0 resets to 1; writing 0 starts it.
// - bits 3:2 read zero; software keeps them on read-modify-write.
// - translation register loads itself during reset, no write needed.
// - changing the crystal code recomputes the translation register.
// - translation register at 0x064 is read-only; writes do nothing.
// - translation bits 13:5 hold pll multiplier; bits 31:14 read zero.
// - translation bits 4:0 hold reference divider; pll = osc*f/(r+1).
// - four-bit crystal code at bits 9:6, reset 0xb, names attached crystal.
`timescale 1ns/1ps

module osc_select_pll_translation
  import osc_pll_pkg::*;
#(
  parameter int unsigned ADDR_WIDTH = osc_pll_pkg::ADDR_W
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [ADDR_WIDTH-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [osc_pll_pkg::DATA_W-1:0] writedata,
  input wire logic [osc_pll_pkg::BE_W-1:0] byteenable,
  output logic [osc_pll_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  output logic [1:0] response,
  output osc_pll_pkg::osc_src_e clock_source_select,
  output logic internal_osc_off,
  output logic main_osc_off,
  output osc_pll_pkg::pll_cfg_s pll_translation
);

  import osc_pll_pkg::*;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } bus_state_e;

  // config fields in their word positions, reserved and upper bits zero
  function automatic logic [DATA_W-1:0] cfg_word(input run_cfg_s c);
    logic [DATA_W-1:0] w;
    w = '0;
    w[CRYSTAL_FREQ_CODE_MSB:CRYSTAL_FREQ_CODE_LSB] = c.crystal_freq_code;
    w[SRC_MSB:SRC_LSB] = c.src;
    w[INT_OSC_OFF_BIT] = c.int_osc_off;
    w[MOSC_OFF_BIT] = c.mosc_off;
    return w;
  endfunction

  // translation fields in their word positions, bits 31:14 zero
  function automatic logic [DATA_W-1:0] pll_word(input pll_cfg_s p);
    logic [DATA_W-1:0] w;
    w = '0;
    w[PLL_F_MSB:PLL_F_LSB] = p.mult;
    w[PLL_R_MSB:PLL_R_LSB] = p.ref_div;
    return w;
  endfunction

  // expands byte enables into a bit mask
  function automatic logic [DATA_W-1:0] lane_mask(input logic [BE_W-1:0] be);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < BE_W; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  bus_state_e bus_q;
  run_cfg_s cfg_q;
  logic [DATA_W-1:0] readdata_q;
  logic [1:0] response_q;
  logic waitrequest_q;
  logic hit_cfg;
  logic hit_pll;
  logic wr_take;
  logic [DATA_W-1:0] merged;
  pll_cfg_s table_now;
  pll_cfg_s pll_cfg_q;

  // address decode on the full byte address
  assign hit_cfg = (address == ADDR_WIDTH'(RUN_CLOCK_CONFIG_OFS));
  assign hit_pll = (address == ADDR_WIDTH'(PLL_TRANSLATION_OFS));
  // a write takes effect only on the edge where waitrequest is seen low
  assign wr_take = write && (bus_q == BUS_ACK);
  // untouched lanes keep their current value
  assign merged = (cfg_word(cfg_q) & ~lane_mask(byteenable))
                | (writedata & lane_mask(byteenable));

  // ----------------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------------
  // one wait cycle per access; waitrequest is a flop so it has no path
  // from the master's inputs, at the cost of one cycle of latency
  always_ff @(posedge clk) begin
    if (srst) begin
      bus_q <= BUS_IDLE;
      waitrequest_q <= 1'b1;
    end else begin
      unique case (bus_q)
        BUS_IDLE: begin
          if (read || write) begin
            bus_q <= BUS_ACK;
            waitrequest_q <= 1'b0;
          end
        end
        BUS_ACK: begin
          bus_q <= BUS_IDLE;
          waitrequest_q <= 1'b1;
        end
      endcase
    end
  end

  // read data and answer code, captured as the request is first seen
  always_ff @(posedge clk) begin
    if (srst) begin
      readdata_q <= '0;
      response_q <= RESP_OKAY;
    end else if ((bus_q == BUS_IDLE) && (read || write)) begin
      response_q <= (hit_cfg || hit_pll) ? RESP_OKAY : RESP_DECODEERROR;
      if (read && hit_cfg) begin
        readdata_q <= cfg_word(cfg_q);
      end else if (read && hit_pll) begin
        // from the table, so a read just after a code write is already current
        readdata_q <= pll_word(table_now);
      end else begin
        readdata_q <= '0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // configuration register
  // ----------------------------------------------------------------------
  // reserved bits 3:2 and everything above bit 9 are simply not stored;
  // writes to the translation offset fall through here and change nothing
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_q <= RUN_CFG_RST;
    end else if (wr_take && hit_cfg) begin
      cfg_q.crystal_freq_code <= merged[CRYSTAL_FREQ_CODE_MSB:CRYSTAL_FREQ_CODE_LSB];
      cfg_q.src <= osc_src_e'(merged[SRC_MSB:SRC_LSB]);
      cfg_q.int_osc_off <= merged[INT_OSC_OFF_BIT];
      cfg_q.mosc_off <= merged[MOSC_OFF_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // crystal to pll translation
  // ----------------------------------------------------------------------
  // the internal oscillator must be chosen as internal/4 when it feeds
  // the pll; nothing here stops software from picking the undivided one
  crystal_freq_code_pll_xlat u_xlat (
    .clk(clk),
    .srst(srst),
    .crystal_freq_code_code(cfg_q.crystal_freq_code),
    .table_now(table_now),
    .pll_cfg_q(pll_cfg_q)
  );

  // ----------------------------------------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------------------------------------
  assign readdata = readdata_q;
  assign waitrequest = waitrequest_q;
  assign response = response_q;
  assign clock_source_select = cfg_q.src;
  assign internal_osc_off = cfg_q.int_osc_off;
  assign main_osc_off = cfg_q.mosc_off;
  assign pll_translation = pll_cfg_q;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  AST_RESET_STATE: assert property (@(posedge clk)
    $past(srst) && !srst |-> clock_source_select == SRC_INTERNAL && !internal_osc_off
      && main_osc_off)
    else $error("config fields not at reset values after reset");

  AST_SRC_WRITE: assert property (@(posedge clk) disable iff (srst)
    write && !waitrequest && hit_cfg && byteenable[0]
      |=> clock_source_select == osc_src_e'($past(writedata[SRC_MSB:SRC_LSB])))
    else $error("source select did not take written value");

  AST_INT_OSC_OFF: assert property (@(posedge clk) disable iff (srst)
    write && !waitrequest && hit_cfg && byteenable[0]
      |=> internal_osc_off == $past(writedata[INT_OSC_OFF_BIT]))
    else $error("internal oscillator off bit did not follow write");

  AST_MOSC_ON: assert property (@(posedge clk) disable iff (srst)
    write && !waitrequest && hit_cfg && byteenable[0] && !writedata[MOSC_OFF_BIT]
      |=> !main_osc_off)
    else $error("writing zero did not enable main oscillator");

  AST_RSV_ZERO: assert property (@(posedge clk) disable iff (srst)
    read && !waitrequest && hit_cfg
      |-> readdata[RSV_MSB:RSV_LSB] == 2'b00 && readdata[DATA_W-1:CRYSTAL_FREQ_CODE_MSB+1] == '0)
    else $error("reserved config bits read nonzero");

  AST_XLAT_RESET: assert property (@(posedge clk)
    $past(srst) && !srst |-> pll_translation == $past(table_now))
    else $error("translation not loaded by reset");

  AST_XLAT_FOLLOW: assert property (@(posedge clk) disable iff (srst)
    $changed(cfg_q.crystal_freq_code) |=> pll_translation == $past(table_now))
    else $error("translation not updated after crystal code change");

  AST_XLAT_RO: assert property (@(posedge clk) disable iff (srst)
    write && !waitrequest && hit_pll ##1 !$changed(cfg_q.crystal_freq_code) |-> $stable(pll_translation))
    else $error("write changed translation register");

  AST_XLAT_READ: assert property (@(posedge clk) disable iff (srst)
    read && !waitrequest && hit_pll |-> readdata[DATA_W-1:PLL_F_MSB+1] == '0
      && readdata[PLL_F_MSB:PLL_F_LSB] == pll_translation.mult
      && readdata[PLL_R_MSB:PLL_R_LSB] == pll_translation.ref_div)
    else $error("translation readback wrong");

  AST_CRYSTAL_FREQ_CODE_WRITE: assert property (@(posedge clk) disable iff (srst)
    write && !waitrequest && hit_cfg && (&byteenable[1:0])
      |=> cfg_q.crystal_freq_code == $past(writedata[CRYSTAL_FREQ_CODE_MSB:CRYSTAL_FREQ_CODE_LSB]) ##1 pll_translation == $past(table_now))
    else $error("crystal code write not carried into translation");

  AST_WAIT_ONE: assert property (@(posedge clk) disable iff (srst)
    (read || write) && waitrequest && bus_q == BUS_IDLE |=> !waitrequest ##1 waitrequest)
    else $error("waitrequest did not drop for exactly one cycle");

  AST_UNMAPPED: assert property (@(posedge clk) disable iff (srst)
    read && !waitrequest && !hit_cfg && !hit_pll |-> readdata == '0
      && response == RESP_DECODEERROR)
    else $error("unmapped read not answered with zero and decode error");

  // ----------------------------------------------------------------------
  // answer timing and held values
  // ----------------------------------------------------------------------
  // these watch the slave side only; they stay quiet whatever the master
  // does between accesses, so back to back traffic is covered as well
  AST_WAIT_LOW_ONCE: assert property (@(posedge clk) disable iff (srst)
    !waitrequest |=> waitrequest)
    else $error("waitrequest stayed low for more than one cycle");

  AST_NO_SPURIOUS_ACK: assert property (@(posedge clk) disable iff (srst)
    waitrequest && !(read || write) |=> waitrequest)
    else $error("waitrequest dropped with no request pending");

  AST_ANSWER_HOLDS: assert property (@(posedge clk) disable iff (srst)
    !(read || write) |=> $stable(readdata) && $stable(response))
    else $error("read data or response moved with no request");

  AST_MAPPED_OKAY: assert property (@(posedge clk) disable iff (srst)
    (read || write) && !waitrequest && (hit_cfg || hit_pll) |-> response == RESP_OKAY)
    else $error("mapped access not answered okay");

  AST_CFG_READBACK: assert property (@(posedge clk) disable iff (srst)
    read && !waitrequest && hit_cfg |-> readdata[CRYSTAL_FREQ_CODE_MSB:CRYSTAL_FREQ_CODE_LSB] == cfg_q.crystal_freq_code
      && readdata[SRC_MSB:SRC_LSB] == clock_source_select
      && readdata[INT_OSC_OFF_BIT] == internal_osc_off
      && readdata[MOSC_OFF_BIT] == main_osc_off)
    else $error("config readback does not match the fields in force");

  AST_CFG_HOLD: assert property (@(posedge clk) disable iff (srst)
    !(write && !waitrequest && hit_cfg) |=> $stable(cfg_q))
    else $error("config register changed without a write to it");

  AST_MOSC_OFF_WR: assert property (@(posedge clk) disable iff (srst)
    write && !waitrequest && hit_cfg && byteenable[0] && writedata[MOSC_OFF_BIT]
      |=> main_osc_off)
    else $error("writing one did not hold main oscillator off");

  // ----------------------------------------------------------------------
  // fixed table entries
  // ----------------------------------------------------------------------
  // checked against literal values rather than the table function, so a
  // slip in the table itself shows up here
  AST_XLAT_CODE_B: assert property (@(posedge clk) disable iff (srst)
    cfg_q.crystal_freq_code == 4'hb |=> pll_translation.mult == 9'h0c8
      && pll_translation.ref_div == 5'h02)
    else $error("code 0xb does not give the 6 mhz setting");

  AST_XLAT_CODE_F: assert property (@(posedge clk) disable iff (srst)
    cfg_q.crystal_freq_code == 4'hf |=> pll_translation.mult == 9'h0f4
      && pll_translation.ref_div == 5'h04)
    else $error("code 0xf does not give the 8.192 mhz setting");

  AST_XLAT_LOW_CODES: assert property (@(posedge clk) disable iff (srst)
    cfg_q.crystal_freq_code < 4'h4 |=> pll_translation == '0)
    else $error("code below 0x4 gave a nonzero pll setting");

  AST_XLAT_STABLE: assert property (@(posedge clk) disable iff (srst)
    $stable(cfg_q.crystal_freq_code) |=> $stable(pll_translation))
    else $error("translation moved while the crystal code held");

endmodule
